// ==== rtl/dtc_codec.sv ====
`timescale 1ns/100ps
`include "dtc_regs.svh"
module dtc_codec import dtc_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // mode: high selects playback
    input wire logic i_play,
    // record inputs from the data source
    input wire logic i_rec_clk,
    input wire logic [`DTC_TRACKS-1:0] i_rec_rz,
    // limited playback signal and complement
    input wire logic i_pb_sig,
    input wire logic i_pb_sig_n,
    // record head drive and erase
    output logic [`DTC_TRACKS-1:0] o_head,
    output logic o_erase,
    // playback outputs
    output logic o_timing,
    output logic o_nrz_data,
    output logic o_nrz_valid
);

    // ==========================================================
    // state and helper decodes
    localparam logic [`DTC_CNT_W-1:0] OS_LIM = `DTC_CNT_W'(`DTC_OS_CYC);
    localparam logic [`DTC_CNT_W-1:0] LOSS_LIM = `DTC_CNT_W'(`DTC_LOSS_CYC);

    dtc_state_type st;
    dtc_state_type next_st;
    logic rise;
    logic fall;
    logic edge_seen;

    // a synchronised level moves only once stages one and two agree
    function automatic logic settle(input logic [`DTC_SYNC_N-1:0] s, input logic cur);
        settle = (s[1] == s[2]) ? s[2] : cur;
    endfunction : settle

    // a playback transition at or past the one-shot window ends a cell
    function automatic logic ends_cell(input logic [`DTC_CNT_W-1:0] c);
        ends_cell = c >= OS_LIM;
    endfunction : ends_cell

    // ==========================================================
    // next-state logic
    always_comb begin
        next_st = st;
        // input synchronisers; stage zero feeds stage one only
        next_st.s_play = {st.s_play[1:0], i_play};
        next_st.s_rclk = {st.s_rclk[1:0], i_rec_clk};
        next_st.s_pb = {st.s_pb[1:0], i_pb_sig};
        next_st.s_pbn = {st.s_pbn[1:0], i_pb_sig_n};
        next_st.play = settle(st.s_play, st.play);
        next_st.rclk = settle(st.s_rclk, st.rclk);
        next_st.pb = settle(st.s_pb, st.pb);
        next_st.pbn = settle(st.s_pbn, st.pbn);
        for (int t = 0; t < `DTC_TRACKS; t++) begin
            next_st.s_rz[t] = {st.s_rz[t][1:0], i_rec_rz[t]};
            next_st.rz[t] = settle(st.s_rz[t], st.rz[t]);
        end

        // clock edges of the sampled record clock
        rise = next_st.rclk & ~st.rclk;
        fall = ~next_st.rclk & st.rclk;

        // encoder per track: a falling edge of (not data OR clock) happens at
        // every cell start and, for a one, again when the clock drops mid-cell
        for (int t = 0; t < `DTC_TRACKS; t++) begin
            if (st.rclk && st.rz[t]) begin
                next_st.one[t] = 1'b1; // one pulse rides the high half
            end
            if (!st.play && (rise || (fall && st.one[t]))) begin
                next_st.head[t] = ~st.head[t];
            end
            if (rise) begin
                next_st.one[t] = 1'b0;
            end
        end

        // erase follows record mode, one cycle behind the mode level
        next_st.erase = ~st.play;

        // complement check: a level is taken only when both lines disagree,
        // so a glitch on one line alone never makes an edge
        if (st.pb != st.pbn) begin
            next_st.lvl = st.pb;
        end
        edge_seen = next_st.lvl != st.lvl;

        // one-shot timing extractor and decoder
        next_st.timing = 1'b0;
        next_st.valid = 1'b0;
        if (!st.play) begin
            next_st.cnt = LOSS_LIM;
            next_st.locked = 1'b0;
            next_st.mid = 1'b0;
        end else if (edge_seen && ends_cell(st.cnt)) begin
            // cell boundary: fire the one-shot, sample the cell just ended
            next_st.timing = 1'b1;
            next_st.valid = st.locked;
            // the boundary that takes lock keeps the old bit, no full cell was seen
            if (st.locked) begin
                next_st.nrz = st.mid;
            end
            next_st.mid = 1'b0;
            next_st.cnt = '0;
            next_st.locked = 1'b1;
        end else if (edge_seen) begin
            // transition inside the window marks a one, of either polarity
            next_st.mid = 1'b1;
            next_st.cnt = st.cnt + 1'b1;
        end else if (st.cnt != LOSS_LIM) begin
            next_st.cnt = st.cnt + 1'b1;
        end else begin
            next_st.locked = 1'b0;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
            st.cnt <= LOSS_LIM;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign o_head = st.head;
    assign o_erase = st.erase;
    assign o_timing = st.timing;
    assign o_nrz_data = st.nrz;
    assign o_nrz_valid = st.valid;

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_rec_cell_start;
        !st.play && rise;
    endsequence

    sequence s_rec_mid_one(int t);
        !st.play && fall && st.one[t];
    endsequence

    sequence s_boundary;
        st.play && edge_seen && ends_cell(st.cnt);
    endsequence

    // playback edge that falls inside the one-shot window
    sequence s_mid_edge;
        st.play && edge_seen && !ends_cell(st.cnt);
    endsequence

    // no transition for two cells while playing back
    sequence s_idle_limit;
        st.play && !edge_seen && st.cnt == LOSS_LIM;
    endsequence

    // complement agrees with the signal, so nothing may be taken
    sequence s_lines_agree;
        st.pb == st.pbn;
    endsequence

    AST_ERASE_ONLY_REC: assert property (st.play |=> !o_erase)
        else $error("erase active during playback");

    AST_BOUNDARY_TOGGLE: assert property (s_rec_cell_start |=> o_head == ~$past(o_head))
        else $error("no transition at cell boundary");

    AST_ONE_MID0: assert property (s_rec_mid_one(0) |=> o_head[0] != $past(o_head[0]))
        else $error("track 0 one bit lacks mid transition");

    AST_ONE_MID1: assert property (s_rec_mid_one(1) |=> o_head[1] != $past(o_head[1]))
        else $error("track 1 one bit lacks mid transition");

    AST_ZERO_NO_MID: assert property (!st.play && fall && st.one == '0 |=> $stable(o_head))
        else $error("zero bit has mid transition");

    AST_HEAD_QUIET_PLAY: assert property (st.play |=> $stable(o_head))
        else $error("head driven during playback");

    AST_TIMING_PULSE: assert property (s_boundary |=> o_timing ##1 !o_timing)
        else $error("timing pulse missing or too long");

    AST_ONESHOT_HOLD: assert property (o_timing |=> !o_timing[*8])
        else $error("one-shot retriggered inside window");

    AST_NRZ_SAMPLE: assert property (s_boundary ##0 st.locked |=> o_nrz_valid && o_nrz_data == $past(st.mid))
        else $error("decoded bit not the sampled cell");

    AST_VALID_WITH_TIMING: assert property (o_nrz_valid |-> o_timing)
        else $error("bit out without timing pulse");

    AST_ERASE_IN_REC: assert property (!st.play |=> o_erase)
        else $error("erase off during record");

    AST_HEAD_NO_EDGE: assert property (!rise && !fall |=> $stable(o_head))
        else $error("head moved without a clock edge");

    AST_DECODE_IDLE_REC: assert property (!st.play |=> !o_timing && !o_nrz_valid)
        else $error("decoder active during record");

    AST_MID_NO_TIMING: assert property (s_mid_edge |=> !o_timing)
        else $error("timing pulse inside one-shot window");

    AST_MID_MARKS_ONE: assert property (s_mid_edge |=> st.mid)
        else $error("mid-cell transition not marked");

    AST_LOCK_DROP: assert property (s_idle_limit |=> !st.locked)
        else $error("lock kept without transitions");

    AST_AGREE_HOLDS_LVL: assert property (s_lines_agree |=> $stable(st.lvl))
        else $error("level taken while lines agree");

    AST_NRZ_HELD: assert property (!o_nrz_valid |-> $stable(o_nrz_data))
        else $error("nrz data changed without valid");

endmodule : dtc_codec

// ==== rtl/dtc_pkg.sv ====
`include "dtc_regs.svh"
package dtc_pkg;
    // ==========================================================
    // state of the codec, registered as one word
    typedef struct packed {
        logic [`DTC_SYNC_N-1:0] s_play;
        logic [`DTC_SYNC_N-1:0] s_rclk;
        logic [`DTC_TRACKS-1:0][`DTC_SYNC_N-1:0] s_rz;
        logic [`DTC_SYNC_N-1:0] s_pb;
        logic [`DTC_SYNC_N-1:0] s_pbn;
        logic play;
        logic rclk;
        logic [`DTC_TRACKS-1:0] rz;
        logic pb;
        logic pbn;
        logic [`DTC_TRACKS-1:0] one;
        logic [`DTC_TRACKS-1:0] head;
        logic erase;
        logic lvl;
        logic [`DTC_CNT_W-1:0] cnt;
        logic locked;
        logic mid;
        logic timing;
        logic valid;
        logic nrz;
    } dtc_state_type;
endpackage : dtc_pkg

// ==== rtl/dtc_regs.svh ====
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH
// ==========================================================
// Operation
// - encoder toggles one flip-flop on falling edges of inverted data OR clock
// - a zero bit gives one boundary transition and no mid-cell transition
// - a one bit adds a mid-cell transition, so ones run at full rate
// - two tracks are encoded and recorded at the same time
// - erase is on only in record mode, never during playback
// - playback decodes cells arriving at 22 times the record rate
// - one-shot extractor takes signal and complement, pulses once per cell
// - each bit is sampled with the timing pulse and sent out as NRZ
// ==========================================================
// rates and derived cycle counts
`define DTC_CLK_HZ 32'h02FA_F080
`define DTC_REC_BPS 32'h0000_1400
`define DTC_PB_SPEED 32'h0000_0016
`define DTC_CELL_CYC (`DTC_CLK_HZ / (`DTC_REC_BPS * `DTC_PB_SPEED))
// one-shot window is three quarters of a cell
`define DTC_OS_NUM 32'h3
`define DTC_OS_DEN 32'h4
`define DTC_OS_CYC (`DTC_CELL_CYC * `DTC_OS_NUM / `DTC_OS_DEN)
// lock is dropped after two cells with no transition
`define DTC_LOSS_CELLS 32'h2
`define DTC_LOSS_CYC (`DTC_CELL_CYC * `DTC_LOSS_CELLS)
`define DTC_CNT_W 10
`define DTC_TRACKS 2
`define DTC_SYNC_N 3
`endif

// ==== sim/dtc_src_model.sv ====
`timescale 1ns/100ps
`include "dtc_regs.svh"
module dtc_src_model (
    // bench clock
    input wire logic i_clk,
    // record clock and return-to-zero data per track
    output logic o_rec_clk,
    output logic [`DTC_TRACKS-1:0] o_rec_rz
);
    // ==========================================================
    // bit source
    // clock stands low between frames, data returns to zero each bit
    initial begin
        o_rec_clk = 1'h0;
        o_rec_rz = 2'h0;
    end
    // one bit per 160 ns, msb first, high half of 4 cycles
    task automatic send(input logic [7:0] b0, input logic [7:0] b1);
        for (int i = 7; i >= 0; i--) begin
            @(negedge i_clk);
            o_rec_clk = 1'h1;
            o_rec_rz = {b1[i], b0[i]};
            repeat (4) @(negedge i_clk);
            o_rec_clk = 1'h0;
            o_rec_rz = 2'h0;
            repeat (3) @(negedge i_clk);
        end
    endtask : send
endmodule : dtc_src_model

// ==== sim/tb.sv ====
`timescale 1ns/100ps
`include "dtc_regs.svh"
module tb;
    logic i_clk, i_nrst, i_play, i_rec_clk, i_pb_sig, i_pb_sig_n;
    logic [1:0] i_rec_rz, o_head, ph;
    logic o_erase, o_timing, o_nrz_data, o_nrz_valid, glitch, pn;
    logic q [$];
    int n_fail = 0, checks = 0, n0 = 0, n1 = 0, ntim = 0, nbad = 0;
    // rows: track 0 bits, track 1 bits, expected head toggles per track
    logic [25:0] rows [4] = '{{8'h00, 8'hFF, 5'h08, 5'h10}, {8'hA5, 8'h0F, 5'h0C, 5'h0C},
        {8'h81, 8'h7E, 5'h0A, 5'h0E}, {8'hFF, 8'h00, 5'h10, 5'h08}};
    // ==========================================================
    // instances
    // glitch lets the signal move while its complement stays put
    assign i_pb_sig_n = ~i_pb_sig ^ glitch;
    dtc_src_model src_u (.i_clk(i_clk), .o_rec_clk(i_rec_clk), .o_rec_rz(i_rec_rz));
    dtc_codec dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_play(i_play), .i_rec_clk(i_rec_clk),
        .i_rec_rz(i_rec_rz), .i_pb_sig(i_pb_sig), .i_pb_sig_n(i_pb_sig_n), .o_head(o_head),
        .o_erase(o_erase), .o_timing(o_timing), .o_nrz_data(o_nrz_data),
        .o_nrz_valid(o_nrz_valid));
    // 50 MHz clock
    initial begin
        i_clk = 1'h0;
        forever #10 i_clk = ~i_clk;
    end
    // monitor on the falling edge, where outputs have settled
    always @(negedge i_clk) begin
        if (o_head[0] !== ph[0]) n0++;
        if (o_head[1] !== ph[1]) n1++;
        ph = o_head;
        if (o_nrz_valid !== 1'h1 && o_nrz_data !== pn) nbad++;
        pn = o_nrz_data;
        if (o_timing === 1'h1) ntim++;
        if (o_nrz_valid === 1'h1) q.push_back(o_nrz_data);
    end
    // ==========================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // one byte per track; 8 idle cycles cover the head latency
    task automatic rec(input logic [25:0] r);
        n0 = 0;
        n1 = 0;
        src_u.send(r[25:18], r[17:10]);
        repeat (8) @(negedge i_clk);
        chk("head0 toggles", {27'h0, r[9:5]}, n0);
        chk("head1 toggles", {27'h0, r[4:0]}, n1);
    endtask : rec
    // diphase cells of 443 cycles after an idle long enough to drop lock
    task automatic pb(input logic [7:0] b, input logic pol);
        i_pb_sig = pol;
        repeat (1000) @(negedge i_clk);
        q.delete();
        ntim = 0;
        for (int i = 7; i >= -1; i--) begin
            i_pb_sig = ~i_pb_sig;
            repeat (221) @(negedge i_clk);
            if (i >= 0 && b[i & 7]) i_pb_sig = ~i_pb_sig;
            repeat (222) @(negedge i_clk);
        end
        chk("valid count", 32'h8, q.size());
        chk("timing count", 32'h9, ntim);
        for (int i = 0; i < 8 && i < q.size(); i++) begin
            chk("nrz bit", {31'h0, b[7 - i]}, {31'h0, q[i]});
        end
    endtask : pb
    // ==========================================================
    // main sequence
    initial begin
        i_nrst = 1'h0;
        i_play = 1'h0;
        i_pb_sig = 1'h0;
        glitch = 1'h0;
        ph = 2'h0;
        pn = 1'h0;
        repeat (2) @(negedge i_clk);
        chk("head in reset", 32'h0, {30'h0, o_head});
        chk("erase in reset", 32'h0, {31'h0, o_erase});
        i_nrst = 1'h1;
        repeat (4) @(negedge i_clk);
        chk("erase in record", 32'h1, {31'h0, o_erase});
        $display("reset test done");
        for (int r = 0; r < 4; r++) begin
            rec(rows[r]);
        end
        $display("record table done");
        // playback: erase off and head frozen
        i_play = 1'h1;
        repeat (8) @(negedge i_clk);
        chk("erase in playback", 32'h0, {31'h0, o_erase});
        rec(26'h3FFFC00);
        $display("mode test done");
        pb(8'hB2, 1'h0);
        pb(8'h4D, 1'h1);
        $display("playback test done");
        // signal toggles twice while its complement holds: nothing is taken
        ntim = 0;
        i_pb_sig = ~i_pb_sig;
        glitch = 1'h1;
        repeat (20) @(negedge i_clk);
        i_pb_sig = ~i_pb_sig;
        glitch = 1'h0;
        repeat (20) @(negedge i_clk);
        chk("glitch timing", 32'h0, ntim);
        // back to record: erase returns
        i_play = 1'h0;
        repeat (8) @(negedge i_clk);
        chk("erase back in record", 32'h1, {31'h0, o_erase});
        chk("nrz held", 32'h0, nbad);
        $display("awkward test done");
        complete_run();
    end
endmodule : tb
